//--- rtl/dpes_pkg.sv
// Constants and types shared by the DPLL event and reference-fail status block
package dpes_pkg;

	// ----------------------------------------------------------------
	// Bus and register geometry
	// ----------------------------------------------------------------
	localparam int unsigned DPES_ADDR_W = 12;
	localparam int unsigned DPES_DATA_W = 32;
	localparam int unsigned DPES_REG_W = 16;

	// Register indices; byte address is four times the index
	localparam logic [7:0] DPES_LOOP_STATUS_IDX = 8'h65;
	localparam logic [7:0] DPES_EVT_STATUS_IDX = 8'h66;
	localparam logic [7:0] DPES_EVT_MASK_IDX = 8'h67;
	localparam logic [7:0] DPES_EVT_CLEAR_IDX = 8'h68;
	localparam logic [7:0] DPES_LIMIT_FAIL_IDX = 8'h69;

	localparam logic [11:0] DPES_LOOP_STATUS_ADDR = {2'b00, DPES_LOOP_STATUS_IDX, 2'b00};
	localparam logic [11:0] DPES_EVT_STATUS_ADDR = {2'b00, DPES_EVT_STATUS_IDX, 2'b00};
	localparam logic [11:0] DPES_EVT_MASK_ADDR = {2'b00, DPES_EVT_MASK_IDX, 2'b00};
	localparam logic [11:0] DPES_EVT_CLEAR_ADDR = {2'b00, DPES_EVT_CLEAR_IDX, 2'b00};
	localparam logic [11:0] DPES_LIMIT_FAIL_ADDR = {2'b00, DPES_LIMIT_FAIL_IDX, 2'b00};

	// ----------------------------------------------------------------
	// Event flag layout: flag vector index i sits at register bit i+1
	// ----------------------------------------------------------------
	localparam int unsigned DPES_EVT_N = 3;
	localparam int unsigned DPES_EVT_LSB = 1;
	localparam int unsigned DPES_HOLD_IDX = 0;
	localparam int unsigned DPES_REF_IDX = 1;
	localparam int unsigned DPES_LOCK_IDX = 2;
	localparam logic [15:0] DPES_MASK_RST = 16'h000F;
	localparam logic [15:0] DPES_MASK_WR_BITS = 16'h000F;

	// ----------------------------------------------------------------
	// Limit-fail layout: four bits per reference input
	// ----------------------------------------------------------------
	localparam int unsigned DPES_REF_N = 4;
	localparam int unsigned DPES_LIM_GROUP_W = 4;
	localparam int unsigned DPES_LIM_MULTI_LOW_POS = 3;
	localparam int unsigned DPES_LIM_MULTI_HIGH_POS = 2;
	localparam int unsigned DPES_LIM_SINGLE_LOW_POS = 1;
	localparam int unsigned DPES_LIM_SINGLE_HIGH_POS = 0;

	// ----------------------------------------------------------------
	// Loop status register fields
	// ----------------------------------------------------------------
	localparam int unsigned DPES_LS_LOCK_POS = 0;
	localparam int unsigned DPES_LS_REF_LSB = 1;
	localparam int unsigned DPES_LS_MODE_LSB = 3;

	typedef enum logic [1:0] {
		DPES_MODE_TRACK = 2'b00,
		DPES_MODE_NORMAL = 2'b01,
		DPES_MODE_HOLD = 2'b10,
		DPES_MODE_FREE = 2'b11
	} dpes_mode_type;

endpackage : dpes_pkg

//--- rtl/dpes_evt_if.sv
// Interface between the event detector and the sticky flag bank
`timescale 1ns/10ps
interface dpes_evt_if;
	logic [2:0] evt_set;
	logic [2:0] evt_clr;
	logic [2:0] flag;

	modport ctrl (
		output evt_set,
		output evt_clr,
		input flag
	);

	modport bank (
		input evt_set,
		input evt_clr,
		output flag
	);
endinterface : dpes_evt_if

//--- rtl/dpes_flag_bank.sv
// Sticky event flags with set-over-clear priority
`timescale 1ns/10ps
module dpes_flag_bank (
	input wire logic clk_i,
	input wire logic nrst_i,
	dpes_evt_if.bank evt
);
	import dpes_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < DPES_EVT_N; gi++) begin : g_flag
			logic flag_r;
			logic flag_nxt;

			// Set wins over a clear in the same cycle
			assign flag_nxt = evt.evt_set[gi] | (flag_r & ~evt.evt_clr[gi]);

			always_ff @(posedge clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					flag_r <= 1'b0;
				end else begin
					flag_r <= flag_nxt;
				end
			end

			assign evt.flag[gi] = flag_r;
		end
	endgenerate

endmodule : dpes_flag_bank

//--- rtl/dpes_top.sv
// DPLL event flags, event mask and clear, reference limit-fail status over APB
// ----------------------------------------------------------------
// Overview of operation
// - Lock-change flag at event status bit 3; register is read-only.
// - Reference-change flag at bit 2 set when selected reference changes.
// - Holdover flag at bit 1 set on entering or leaving holdover/tracking.
// - Event status bits 15..4 and bit 0 always read zero.
// - Interrupt asserted while any set flag has its mask bit low.
// - Writing one to a clear-register bit clears only that flag.
// - Mask bit 3 high keeps the lock-change flag off the interrupt.
// - Mask bit 2 high keeps the reference-change flag off the interrupt.
// - Mask bit 1 high keeps the holdover flag off the interrupt.
// - Input 3 limit fails at status bits 15..12.
// - Input 2 limit fails at status bits 11..8.
// - Input 1 limit fails at status bits 7..4.
// - Input 0 limit fails at status bits 3..0.
// - Loop mode code: 00 tracking, 01 normal, 10 holdover, 11 freerun.
// ----------------------------------------------------------------
//
// Our own choice: the APB register port.
`timescale 1ns/10ps
module dpes_top (
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [dpes_pkg::DPES_ADDR_W-1:0] PADDR_I,
	input wire logic [dpes_pkg::DPES_DATA_W-1:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [dpes_pkg::DPES_DATA_W-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic LOCK_STATUS_I,
	input wire logic [1:0] SELECTED_REF_I,
	input wire logic [1:0] LOOP_TIMING_MODE_CODE_I,
	input wire logic [dpes_pkg::DPES_REF_N-1:0] MULTI_LOW_FAIL_I,
	input wire logic [dpes_pkg::DPES_REF_N-1:0] MULTI_HIGH_FAIL_I,
	input wire logic [dpes_pkg::DPES_REF_N-1:0] SINGLE_LOW_FAIL_I,
	input wire logic [dpes_pkg::DPES_REF_N-1:0] SINGLE_HIGH_FAIL_I,
	output logic IRQ_O
);
	import dpes_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	dpes_evt_if evt ();

	logic primed_r;
	logic lock_prev_r;
	logic [1:0] sel_ref_prev_r;
	dpes_mode_type mode_prev_r;
	dpes_mode_type mode_cur;

	logic [15:0] mask_r;
	logic [15:0] mask_nxt;
	logic [15:0] limit_fail_r;
	logic [15:0] limit_fail_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic irq_r;
	logic irq_nxt;

	wire setup_phase;
	wire access_phase;
	wire access_wr;
	wire hit_loop;
	wire hit_status;
	wire hit_mask;
	wire hit_clear;
	wire hit_limit;
	wire hit_any;
	wire hit_ro;
	wire req_err;
	wire [15:0] lane_mask;
	wire [15:0] wdata16;
	wire [15:0] loop_status_word;
	wire [15:0] evt_status_word;
	wire [15:0] rd_word;
	wire mask_wr;
	wire clear_wr;
	wire lock_evt;
	wire ref_evt;
	wire hold_evt;
	wire cur_ht;
	wire prev_ht;
	wire [DPES_EVT_N-1:0] flag_enabled;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign setup_phase = PSEL_I & ~PENABLE_I;
	assign access_phase = PSEL_I & PENABLE_I;
	assign access_wr = access_phase & PWRITE_I;

	assign hit_loop = (PADDR_I == DPES_LOOP_STATUS_ADDR);
	assign hit_status = (PADDR_I == DPES_EVT_STATUS_ADDR);
	assign hit_mask = (PADDR_I == DPES_EVT_MASK_ADDR);
	assign hit_clear = (PADDR_I == DPES_EVT_CLEAR_ADDR);
	assign hit_limit = (PADDR_I == DPES_LIMIT_FAIL_ADDR);
	assign hit_any = hit_loop | hit_status | hit_mask | hit_clear | hit_limit;
	assign hit_ro = hit_loop | hit_status | hit_limit;

	// Unmapped addresses and writes to read-only words are refused
	assign req_err = ~hit_any | (PWRITE_I & hit_ro);

	// Only the low two byte lanes carry register bits
	assign lane_mask = {{8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
	assign wdata16 = PWDATA_I[15:0];

	assign mask_wr = access_wr & hit_mask;
	assign clear_wr = access_wr & hit_clear;

	// ----------------------------------------------------------------
	// Read words
	// ----------------------------------------------------------------
	assign evt_status_word = {12'h000, evt.flag, 1'b0};

	assign loop_status_word = {11'h000, mode_cur, SELECTED_REF_I, LOCK_STATUS_I};

	// Clear register is write-only and reads back zero
	assign rd_word = hit_loop ? loop_status_word :
		hit_status ? evt_status_word :
		hit_mask ? mask_r :
		hit_limit ? limit_fail_r :
		16'h0000;

	// Read data is captured in the setup cycle so it comes from a flop
	assign prdata_nxt = setup_phase ? {16'h0000, rd_word} : prdata_r;
	assign pslverr_nxt = setup_phase ? req_err : pslverr_r;

	// No wait states: every access phase completes at once
	assign PREADY_O = 1'b1;
	assign PRDATA_O = prdata_r;
	assign PSLVERR_O = pslverr_r;

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Event mask register
	// ----------------------------------------------------------------
	// Bits 15..4 are not stored, so a stray host write cannot set them
	assign mask_nxt = mask_wr ?
		(((mask_r & ~lane_mask) | (wdata16 & lane_mask)) & DPES_MASK_WR_BITS) : mask_r;

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			mask_r <= DPES_MASK_RST;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Event detection
	// ----------------------------------------------------------------
	assign mode_cur = dpes_mode_type'(LOOP_TIMING_MODE_CODE_I);

	// Primed keeps reset-time values from looking like changes
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			primed_r <= 1'b0;
			lock_prev_r <= 1'b0;
			sel_ref_prev_r <= 2'b00;
			mode_prev_r <= DPES_MODE_FREE;
		end else begin
			primed_r <= 1'b1;
			lock_prev_r <= LOCK_STATUS_I;
			sel_ref_prev_r <= SELECTED_REF_I;
			mode_prev_r <= mode_cur;
		end
	end

	assign lock_evt = primed_r & (LOCK_STATUS_I != lock_prev_r);
	assign ref_evt = primed_r & (SELECTED_REF_I != sel_ref_prev_r);

	// Any mode change into, out of or between holdover and tracking sets the flag
	assign cur_ht = (mode_cur == DPES_MODE_HOLD) | (mode_cur == DPES_MODE_TRACK);
	assign prev_ht = (mode_prev_r == DPES_MODE_HOLD) | (mode_prev_r == DPES_MODE_TRACK);
	assign hold_evt = primed_r & (mode_cur != mode_prev_r) & (cur_ht | prev_ht);

	assign evt.evt_set[DPES_LOCK_IDX] = lock_evt;
	assign evt.evt_set[DPES_REF_IDX] = ref_evt;
	assign evt.evt_set[DPES_HOLD_IDX] = hold_evt;

	// A written one clears only its own flag
	assign evt.evt_clr = clear_wr ?
		(wdata16[DPES_EVT_LSB +: DPES_EVT_N] & lane_mask[DPES_EVT_LSB +: DPES_EVT_N]) :
		3'b000;

	dpes_flag_bank u_flag_bank (
		.clk_i(CORE_CLK_I),
		.nrst_i(NRST_I),
		.evt(evt.bank)
	);

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	// A high mask bit blocks its flag; flags themselves still latch
	assign flag_enabled[DPES_LOCK_IDX] =
		evt.flag[DPES_LOCK_IDX] & ~mask_r[DPES_EVT_LSB + DPES_LOCK_IDX];
	assign flag_enabled[DPES_REF_IDX] =
		evt.flag[DPES_REF_IDX] & ~mask_r[DPES_EVT_LSB + DPES_REF_IDX];
	assign flag_enabled[DPES_HOLD_IDX] =
		evt.flag[DPES_HOLD_IDX] & ~mask_r[DPES_EVT_LSB + DPES_HOLD_IDX];

	assign irq_nxt = |flag_enabled;

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	assign IRQ_O = irq_r;

	// ----------------------------------------------------------------
	// Reference limit-fail status
	// ----------------------------------------------------------------
	// Live follower, not sticky: software sees the current check result
	genvar gr;
	generate
		for (gr = 0; gr < DPES_REF_N; gr++) begin : g_ref
			assign limit_fail_nxt[gr*DPES_LIM_GROUP_W + DPES_LIM_MULTI_LOW_POS] =
				MULTI_LOW_FAIL_I[gr];
			assign limit_fail_nxt[gr*DPES_LIM_GROUP_W + DPES_LIM_MULTI_HIGH_POS] =
				MULTI_HIGH_FAIL_I[gr];
			assign limit_fail_nxt[gr*DPES_LIM_GROUP_W + DPES_LIM_SINGLE_LOW_POS] =
				SINGLE_LOW_FAIL_I[gr];
			assign limit_fail_nxt[gr*DPES_LIM_GROUP_W + DPES_LIM_SINGLE_HIGH_POS] =
				SINGLE_HIGH_FAIL_I[gr];
		end
	endgenerate

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			limit_fail_r <= 16'h0000;
		end else begin
			limit_fail_r <= limit_fail_nxt;
		end
	end

endmodule : dpes_top

//--- testbench/dpes_monitor.sv
// Checker bound to the DPLL event block top
`timescale 1ns/10ps
module dpes_monitor
	import dpes_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [11:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PSLVERR_O,
	input wire logic LOCK_STATUS_I,
	input wire logic [1:0] SELECTED_REF_I,
	input wire logic [1:0] LOOP_TIMING_MODE_CODE_I,
	input wire logic [3:0] MULTI_LOW_FAIL_I,
	input wire logic [3:0] MULTI_HIGH_FAIL_I,
	input wire logic [3:0] SINGLE_LOW_FAIL_I,
	input wire logic [3:0] SINGLE_HIGH_FAIL_I,
	input wire logic IRQ_O
);
	// ----
	// Mask mirror; first edge after reset only primes the detector
	// ----
	logic arm_r;
	logic [3:0] mask_r;
	logic [15:0] lim_w;
	wire wr_w = PSEL_I && PENABLE_I && PWRITE_I;
	wire setup_w = PSEL_I && !PENABLE_I;
	wire mwr_w = wr_w && PADDR_I == DPES_EVT_MASK_ADDR && PSTRB_I[0];
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lim_w[4*i+:4] = {MULTI_LOW_FAIL_I[i], MULTI_HIGH_FAIL_I[i],
				SINGLE_LOW_FAIL_I[i], SINGLE_HIGH_FAIL_I[i]};
		end
	end
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			arm_r <= 1'b0;
			mask_r <= 4'hF;
		end else begin
			arm_r <= 1'b1;
			mask_r <= mwr_w ? PWDATA_I[3:0] : mask_r;
		end
	end
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_quiet;
		!$changed(LOCK_STATUS_I) && !$changed(SELECTED_REF_I) && !$changed(LOOP_TIMING_MODE_CODE_I);
	endsequence
	sequence s_clr_all;
		wr_w && PADDR_I == DPES_EVT_CLEAR_ADDR && PSTRB_I[0] && PWDATA_I[3:1] == 3'h7 ##0 s_quiet;
	endsequence
	sequence s_hold_evt;
		arm_r && $changed(LOOP_TIMING_MODE_CODE_I)
			&& (!LOOP_TIMING_MODE_CODE_I[0] || !$past(LOOP_TIMING_MODE_CODE_I[0]));
	endsequence
	AST_LOCK_IRQ: assert property (arm_r && $changed(LOCK_STATUS_I) ##1 !mask_r[3] |=> IRQ_O)
		else $error("lock change did not raise irq");
	AST_REF_IRQ: assert property (arm_r && $changed(SELECTED_REF_I) ##1 !mask_r[2] |=> IRQ_O)
		else $error("reference change did not raise irq");
	AST_HOLD_IRQ: assert property (s_hold_evt ##1 !mask_r[1] |=> IRQ_O)
		else $error("holdover change did not raise irq");
	AST_ALL_MASKED: assert property (mask_r[3:1] == 3'h7 |=> !IRQ_O)
		else $error("irq high with all events masked");
	AST_CLEAR_ALL: assert property (s_clr_all ##1 s_quiet |=> !IRQ_O)
		else $error("irq high after clearing all flags");
	AST_IRQ_HOLDS: assert property (!wr_w ##1 IRQ_O && !wr_w ##1 !wr_w |=> IRQ_O)
		else $error("irq dropped without host write");
	AST_EVT_RSVD: assert property (setup_w && PADDR_I == DPES_EVT_STATUS_ADDR |=>
		PRDATA_O[31:4] == 28'h0 && !PRDATA_O[0])
		else $error("reserved event bits not zero");
	AST_RO_WR_ERR: assert property (setup_w && PWRITE_I && PADDR_I == DPES_EVT_STATUS_ADDR
		|=> PSLVERR_O)
		else $error("write to event status not refused");
	AST_LIMIT_READ: assert property (arm_r && setup_w && PADDR_I == DPES_LIMIT_FAIL_ADDR
		|=> PRDATA_O == {16'h0, $past(lim_w, 2)})
		else $error("limit status read wrong");
endmodule : dpes_monitor

bind dpes_top dpes_monitor u_mon (
	.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
	.PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .LOCK_STATUS_I(LOCK_STATUS_I),
	.SELECTED_REF_I(SELECTED_REF_I), .LOOP_TIMING_MODE_CODE_I(LOOP_TIMING_MODE_CODE_I),
	.MULTI_LOW_FAIL_I(MULTI_LOW_FAIL_I), .MULTI_HIGH_FAIL_I(MULTI_HIGH_FAIL_I),
	.SINGLE_LOW_FAIL_I(SINGLE_LOW_FAIL_I), .SINGLE_HIGH_FAIL_I(SINGLE_HIGH_FAIL_I),
	.IRQ_O(IRQ_O));

//--- testbench/dpes_dpll_model.sv
// Behavioural DPLL status source for the block's status inputs
`timescale 1ns/10ps
module dpes_dpll_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic lock_i,
	input wire logic [1:0] ref_i,
	input wire logic [1:0] mode_i,
	input wire logic [15:0] lim_i,
	output logic lock_o,
	output logic [1:0] ref_o,
	output logic [1:0] mode_o,
	output logic [15:0] lim_o
);
	// Outputs change only on the clock, as the loop logic would
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lock_o <= 1'b0;
			ref_o <= 2'h0;
			mode_o <= 2'h1;
			lim_o <= 16'h0;
		end else begin
			lock_o <= lock_i;
			ref_o <= ref_i;
			mode_o <= mode_i;
			lim_o <= lim_i;
		end
	end
endmodule : dpes_dpll_model

//--- testbench/dpes_top_test.sv
// Self-checking bench for the DPLL event and limit-fail status block
`timescale 1ns/10ps
module dpes_top_test;
	import dpes_pkg::*;
	localparam logic [11:0] ST = DPES_EVT_STATUS_ADDR;
	localparam logic [11:0] MK = DPES_EVT_MASK_ADDR;
	localparam logic [11:0] CL = DPES_EVT_CLEAR_ADDR;
	localparam logic [11:0] LM = DPES_LIMIT_FAIL_ADDR;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, irq, rerr, lock_s, lock_v = 1'b0;
	logic [1:0] ref_v = 2'h0, mode_v = 2'h1, ref_s, mode_s;
	logic [15:0] lim_v = 16'h0, lim_s;
	int fail_count = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	dpes_dpll_model u_dpll (.clk_i(clk), .nrst_i(nrst), .lock_i(lock_v), .ref_i(ref_v),
		.mode_i(mode_v), .lim_i(lim_v), .lock_o(lock_s), .ref_o(ref_s), .mode_o(mode_s),
		.lim_o(lim_s));
	dpes_top uut (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
		.PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .LOCK_STATUS_I(lock_s), .SELECTED_REF_I(ref_s),
		.LOOP_TIMING_MODE_CODE_I(mode_s), .MULTI_LOW_FAIL_I({lim_s[15], lim_s[11], lim_s[7], lim_s[3]}),
		.MULTI_HIGH_FAIL_I({lim_s[14], lim_s[10], lim_s[6], lim_s[2]}),
		.SINGLE_LOW_FAIL_I({lim_s[13], lim_s[9], lim_s[5], lim_s[1]}),
		.SINGLE_HIGH_FAIL_I({lim_s[12], lim_s[8], lim_s[4], lim_s[0]}), .IRQ_O(irq));
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			finish_test;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rdat);
	endtask : rchk
	function automatic logic hold_exp(input logic [1:0] o, input logic [1:0] n);
		return (o != n) && (!o[0] || !n[0]);
	endfunction : hold_exp
	task automatic evt(input int k, input logic msk);
		logic [31:0] b;
		b = 32'h1 << k;
		apb(1'b1, MK, 32'h1 | (msk ? b : 32'h0));
		apb(1'b1, CL, 32'hE);
		case (k)
			1: mode_v <= ~mode_v;
			2: ref_v <= ref_v + 2'h1;
			default: lock_v <= ~lock_v;
		endcase
		cyc(4);
		@(negedge clk);
		chk("irq", {31'h0, !msk}, {31'h0, irq});
		rchk("flag", ST, b);
		apb(1'b1, CL, 32'hE & ~b);
		rchk("flag kept", ST, b);
		apb(1'b1, CL, b);
		cyc(2);
		rchk("flag cleared", ST, 32'h0);
		@(negedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
	endtask : evt
	initial begin
		#(25 * 100000);
		fail_count++;
		finish_test;
	end
	// ----
	// Main sequence
	// ----
	initial begin
		logic [3:0] m;
		void'($urandom(32'hd9d491dc));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		cyc(3);
		rchk("mask reset", MK, 32'hF);
		rchk("event reset", ST, 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, rerr});
		apb(1'b1, ST, 32'hE);
		chk("ro err", 32'h1, {31'h0, rerr});
		for (int k = 1; k < 4; k++) begin
			evt(k, 1'b0);
			evt(k, 1'b1);
		end
		for (int i = 0; i < 16; i++) begin
			mode_v <= i[3:2];
			cyc(3);
			apb(1'b1, CL, 32'hE);
			mode_v <= i[1:0];
			cyc(3);
			rchk("hold flag", ST, {30'h0, hold_exp(i[3:2], i[1:0]), 1'b0});
			rchk("loop status", DPES_LOOP_STATUS_ADDR, {27'h0, i[1:0], ref_v, lock_v});
		end
		// Lock change lands on the very edge that the clear takes effect
		fork
			apb(1'b1, CL, 32'hE);
			begin
				@(posedge clk);
				lock_v <= ~lock_v;
			end
		join
		rchk("set over clear", ST, 32'h8);
		apb(1'b1, CL, 32'h8);
		rchk("late clear", ST, 32'h0);
		for (int i = 0; i < 25; i++) begin
			lim_v <= (i < 16) ? 16'h1 << i : (i < 24 ? 16'($urandom) : 16'h0);
			cyc(3);
			rchk("limits", LM, {16'h0, lim_v});
		end
		for (int i = 0; i < 4; i++) begin
			m = {3'($urandom), 1'b1};
			apb(1'b1, MK, {28'h0, m});
			rchk("mask", MK, {28'h0, m});
		end
		finish_test;
	end
endmodule : dpes_top_test
